// >>> logic/pdm_dma_path.v
`timescale 1ns/10ps
`include "pdm_dma_defs.vh"

module pdm_dma_path (
  input  wire        clock_i,
  input  wire        srst_i,
  input  wire        dma_req_i,
  input  wire [3:0]  dma_cmd_i,
  input  wire [31:0] dma_addr_i,
  input  wire        dma_end_i,
  output wire        dma_busy_o,
  output wire [63:0] rd_data_o,
  output wire        rd_valid_o,
  input  wire        rd_ready_i,
  input  wire [63:0] wr_data_i,
  input  wire [7:0]  wr_be_i,
  input  wire        wr_valid_i,
  output wire        wr_ready_o,
  output wire        probe_req_o,
  output wire        probe_flush_o,
  output wire [31:0] probe_addr_o,
  input  wire        probe_ack_i,
  input  wire        probe_dirty_i,
  output wire        mem_req_o,
  output wire        mem_we_o,
  output wire [31:0] mem_addr_o,
  output wire        fill_buf_o,
  output wire        cache_copy_o,
  input  wire        mem_done_i,
  input  wire        cpu_mem_req_i,
  input  wire        cpu_mem_done_i,
  output wire        cpu_mem_gnt_o,
  output wire        qw_req_o,
  output wire        qw_buf_o,
  output wire [2:0]  qw_idx_o,
  output wire [1:0]  qw_src_o,
  input  wire [63:0] qw_data_i,
  input  wire [7:0]  qw_ecc_i,
  input  wire        qw_valid_i,
  output wire        pw_we_o,
  output wire [2:0]  pw_idx_o,
  output wire [63:0] pw_data_o,
  output wire [7:0]  pw_ecc_o,
  input  wire        io_rd_req_i,
  input  wire        cpu_io_wr_pend_i,
  output wire        io_rd_go_o
);

  // ----------------------------------------
  // check code helpers
  // ----------------------------------------
  // each data bit owns code {11, index}; syndrome names the bad bit
  function [7:0] ecc_gen;
    input [63:0] d;
    integer j;
    begin
      ecc_gen = 8'h00;
      for (j = 0; j < 64; j = j + 1) begin
        if (d[j]) begin
          ecc_gen = ecc_gen ^ {`PDM_ECC_TAG, j[5:0]};
        end
      end
    end
  endfunction

  function [63:0] ecc_fix;
    input [63:0] d;
    input [7:0]  c;
    reg   [7:0]  syn;
    begin
      syn     = ecc_gen(d) ^ c;
      ecc_fix = d;
      if (syn[7:6] == `PDM_ECC_TAG) begin
        ecc_fix[syn[5:0]] = ~d[syn[5:0]];
      end
    end
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [3:0]  st_q;
  reg [1:0]  own_q;
  reg        rd_act_q;
  reg        wr_mode_q;
  reg [3:0]  cmd_q;
  reg [25:0] blk_q;
  reg        pf_used_q;
  reg        fb_q;
  reg        rb_q;
  reg [1:0]  dbv_q;
  reg [1:0]  cvld_q;
  reg [2:0]  didx_q;
  reg        req_out_q;
  reg        qrd_q;
  reg [63:0] rbuf [0:7];
  reg [7:0]  ent_v_q;
  reg [2:0]  wptr_q;
  reg [2:0]  rptr_q;
  reg        out_v_q;
  reg [63:0] out_data_q;
  reg [3:0]  wq_q;
  reg [2:0]  wstart_q;
  reg        wend_q;
  reg [63:0] mdata_q;
  reg [7:0]  mbe_q;
  reg        probe_req_q;
  reg        mem_req_q;
  reg        mem_we_q;
  reg        cache_copy_q;
  reg        qw_req_q;
  reg        qw_buf_q;
  reg [2:0]  qw_idx_q;
  reg [1:0]  qw_src_q;
  reg        pw_we_q;
  reg [2:0]  pw_idx_q;
  reg [63:0] pw_data_q;
  reg [7:0]  pw_ecc_q;
  reg        wr_ready_q;
  reg        busy_q;
  reg        cpu_gnt_q;
  reg        io_go_q;

  // ----------------------------------------
  // read data steering
  // ----------------------------------------
  wire [63:0] cor_data = ecc_fix(qw_data_i, qw_ecc_i);
  wire        rd_ans   = qw_valid_i && qrd_q;
  wire        pop_ok   = !out_v_q || rd_ready_i;
  wire        bypass   = rd_ans && rd_act_q && (ent_v_q == 8'h00) && pop_ok;
  wire        stash    = rd_ans && rd_act_q && !bypass;
  wire        pop      = ent_v_q[rptr_q] && pop_ok;
  wire        drn_go   = rd_act_q && dbv_q[rb_q] && !req_out_q && !ent_v_q[wptr_q];
  wire        demand   = (ent_v_q == 8'h00) && (dbv_q == 2'h0) && !req_out_q;
  wire        pf_ok    = (cmd_q == `PDM_CMD_MRM) ||
                         ((cmd_q == `PDM_CMD_MRL) && !pf_used_q);
  wire        page_end = (blk_q[6:0] == `PDM_PAGE_LAST);
  wire        is_rd    = (dma_cmd_i == `PDM_CMD_MR) || (dma_cmd_i == `PDM_CMD_MRL) ||
                         (dma_cmd_i == `PDM_CMD_MRM);
  wire        is_wr    = (dma_cmd_i == `PDM_CMD_MW) || (dma_cmd_i == `PDM_CMD_MWI);
  wire        w_fill   = wend_q || (wq_q[2:0] < wstart_q);

  // ----------------------------------------
  // write merge: valid bytes overlay fetched quadword
  // ----------------------------------------
  wire [63:0] merged;
  genvar b;
  generate
    for (b = 0; b < 8; b = b + 1) begin : g_merge
      assign merged[b*8+7:b*8] = mbe_q[b] ? mdata_q[b*8+7:b*8] : cor_data[b*8+7:b*8];
    end
  endgenerate

  // ----------------------------------------
  // main sequencer
  // ----------------------------------------
  always @(posedge clock_i) begin
    if (srst_i) begin
      st_q         <= `PDM_ST_IDLE;
      own_q        <= `PDM_OWN_NONE;
      rd_act_q     <= 1'b0;
      wr_mode_q    <= 1'b0;
      cmd_q        <= 4'h0;
      blk_q        <= 26'h000_0000;
      pf_used_q    <= 1'b0;
      fb_q         <= 1'b0;
      rb_q         <= 1'b0;
      dbv_q        <= 2'h0;
      cvld_q       <= 2'h0;
      didx_q       <= 3'h0;
      req_out_q    <= 1'b0;
      qrd_q        <= 1'b0;
      ent_v_q      <= 8'h00;
      wptr_q       <= 3'h0;
      rptr_q       <= 3'h0;
      out_v_q      <= 1'b0;
      out_data_q   <= 64'h0000_0000_0000_0000;
      wq_q         <= 4'h0;
      wstart_q     <= 3'h0;
      wend_q       <= 1'b0;
      mdata_q      <= 64'h0000_0000_0000_0000;
      mbe_q        <= 8'h00;
      probe_req_q  <= 1'b0;
      mem_req_q    <= 1'b0;
      mem_we_q     <= 1'b0;
      cache_copy_q <= 1'b0;
      qw_req_q     <= 1'b0;
      qw_buf_q     <= 1'b0;
      qw_idx_q     <= 3'h0;
      qw_src_q     <= `PDM_SRC_MEM;
      pw_we_q      <= 1'b0;
      pw_idx_q     <= 3'h0;
      pw_data_q    <= 64'h0000_0000_0000_0000;
      pw_ecc_q     <= 8'h00;
      wr_ready_q   <= 1'b0;
      busy_q       <= 1'b0;
      cpu_gnt_q    <= 1'b0;
      io_go_q      <= 1'b0;
    end else begin
      // one-cycle strobes default low
      probe_req_q  <= 1'b0;
      mem_req_q    <= 1'b0;
      cache_copy_q <= 1'b0;
      qw_req_q     <= 1'b0;
      pw_we_q      <= 1'b0;
      wr_ready_q   <= 1'b0;
      busy_q       <= (st_q != `PDM_ST_IDLE) || rd_act_q || req_out_q;
      io_go_q      <= io_rd_req_i && !cpu_io_wr_pend_i;

      // cpu takes memory only when nobody owns it
      if (own_q == `PDM_OWN_CPU && cpu_mem_done_i) begin
        own_q     <= `PDM_OWN_NONE;
        cpu_gnt_q <= 1'b0;
      end else if (own_q == `PDM_OWN_NONE && cpu_mem_req_i && st_q != `PDM_ST_OWN) begin
        own_q     <= `PDM_OWN_CPU;
        cpu_gnt_q <= 1'b1;
      end

      // fetch engine
      case (st_q)
        `PDM_ST_IDLE: begin
          if (dma_req_i && !rd_act_q && !req_out_q && (is_rd || is_wr)) begin
            busy_q    <= 1'b1;
            blk_q     <= dma_addr_i[31:6];
            cmd_q     <= dma_cmd_i;
            wr_mode_q <= is_wr;
            rd_act_q  <= is_rd;
            pf_used_q <= 1'b0;
            fb_q      <= 1'b0;
            rb_q      <= 1'b0;
            didx_q    <= dma_addr_i[5:3];
            wq_q      <= 4'h0;
            wstart_q  <= dma_addr_i[5:3];
            wend_q    <= 1'b0;
            st_q      <= `PDM_ST_OWN;
          end
        end
        `PDM_ST_OWN: begin
          if (own_q == `PDM_OWN_NONE) begin
            own_q       <= `PDM_OWN_DMA;
            probe_req_q <= 1'b1;
            st_q        <= `PDM_ST_PROBE;
          end
        end
        `PDM_ST_PROBE: begin
          if (probe_ack_i) begin
            cache_copy_q  <= probe_dirty_i;
            cvld_q[fb_q]  <= probe_dirty_i;
            mem_req_q     <= 1'b1;
            mem_we_q      <= 1'b0;
            st_q          <= `PDM_ST_MEM;
          end
        end
        `PDM_ST_MEM: begin
          if (mem_done_i) begin
            if (wr_mode_q) begin
              st_q <= `PDM_ST_WDATA;
            end else begin
              own_q <= `PDM_OWN_NONE;
              if (rd_act_q) begin
                dbv_q[fb_q] <= 1'b1;
                fb_q        <= ~fb_q;
              end
              st_q <= `PDM_ST_RIDLE;
            end
          end
        end
        `PDM_ST_RIDLE: begin
          if (!rd_act_q) begin
            st_q <= `PDM_ST_IDLE;
          end else if (!dbv_q[fb_q] && !page_end && (demand || pf_ok)) begin
            blk_q     <= blk_q + 26'h000_0001;
            pf_used_q <= pf_used_q || !demand;
            st_q      <= `PDM_ST_OWN;
          end
        end
        `PDM_ST_WDATA: begin
          if (wq_q == `PDM_QW_COUNT) begin
            st_q <= `PDM_ST_COMMIT;
          end else if (w_fill) begin
            mbe_q    <= 8'h00;
            qw_req_q <= 1'b1;
            st_q     <= `PDM_ST_WMERGE;
          end else if (wr_valid_i && wr_ready_q) begin
            if (wr_be_i == `PDM_BE_ALL) begin
              pw_we_q   <= 1'b1;
              pw_data_q <= wr_data_i;
              pw_ecc_q  <= ecc_gen(wr_data_i);
              wq_q      <= wq_q + 4'h1;
              wr_ready_q <= (wq_q[2:0] != `PDM_QW_LAST) && !dma_end_i;
            end else begin
              mdata_q  <= wr_data_i;
              mbe_q    <= wr_be_i;
              qw_req_q <= 1'b1;
              st_q     <= `PDM_ST_WMERGE;
            end
          end else begin
            wr_ready_q <= !dma_end_i;
          end
          pw_idx_q <= wq_q[2:0];
          qw_idx_q <= wq_q[2:0];
          qw_buf_q <= fb_q;
          qw_src_q <= cvld_q[fb_q] ? `PDM_SRC_CACHE : `PDM_SRC_MEM;
        end
        `PDM_ST_WMERGE: begin
          if (qw_valid_i) begin
            pw_we_q   <= 1'b1;
            pw_data_q <= merged;
            pw_ecc_q  <= ecc_gen(merged);
            wq_q      <= wq_q + 4'h1;
            st_q      <= `PDM_ST_WDATA;
          end
        end
        `PDM_ST_COMMIT: begin
          mem_req_q <= 1'b1;
          mem_we_q  <= 1'b1;
          st_q      <= `PDM_ST_WAITW;
        end
        `PDM_ST_WAITW: begin
          if (mem_done_i) begin
            own_q <= `PDM_OWN_NONE;
            if (wend_q) begin
              st_q <= `PDM_ST_IDLE;
            end else begin
              blk_q    <= blk_q + 26'h000_0001;
              wq_q     <= 4'h0;
              wstart_q <= 3'h0;
              st_q     <= `PDM_ST_OWN;
            end
          end
        end
        default: begin
          st_q <= `PDM_ST_IDLE;
        end
      endcase

      // drain engine: pull quadwords from the data switch buffers
      if (drn_go) begin
        req_out_q <= 1'b1;
        qrd_q     <= 1'b1;
        qw_req_q  <= 1'b1;
        qw_buf_q  <= rb_q;
        qw_idx_q  <= didx_q;
        qw_src_q  <= cvld_q[rb_q] ? `PDM_SRC_CACHE : `PDM_SRC_MEM;
      end
      if (qw_valid_i) begin
        req_out_q <= 1'b0;
        qrd_q     <= 1'b0;
        if (rd_ans && rd_act_q) begin
          didx_q <= didx_q + 3'h1;
          if (didx_q == `PDM_QW_LAST) begin
            dbv_q[rb_q] <= 1'b0;
            rb_q        <= ~rb_q;
          end
        end
      end

      // eight-entry read queue; an answer skips it when it is empty and the output can take it
      if (stash) begin
        rbuf[wptr_q]    <= cor_data;
        ent_v_q[wptr_q] <= 1'b1;
        wptr_q          <= wptr_q + 3'h1;
      end
      if (bypass) begin
        out_data_q <= cor_data;
        out_v_q    <= 1'b1;
      end else if (pop) begin
        out_data_q      <= rbuf[rptr_q];
        out_v_q         <= 1'b1;
        ent_v_q[rptr_q] <= 1'b0;
        rptr_q          <= rptr_q + 3'h1;
      end else if (rd_ready_i) begin
        out_v_q <= 1'b0;
      end

      // transaction end drops every prefetched quadword
      if (dma_end_i) begin
        if (rd_act_q) begin
          rd_act_q <= 1'b0;
          ent_v_q  <= 8'h00;
          dbv_q    <= 2'h0;
          out_v_q  <= 1'b0;
          wptr_q   <= 3'h0;
          rptr_q   <= 3'h0;
        end
        if (wr_mode_q) begin
          wend_q <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign dma_busy_o    = busy_q;
  assign rd_data_o     = out_data_q;
  assign rd_valid_o    = out_v_q;
  assign wr_ready_o    = wr_ready_q;
  assign probe_req_o   = probe_req_q;
  assign probe_flush_o = wr_mode_q;
  assign probe_addr_o  = {blk_q, 6'h00};
  assign mem_req_o     = mem_req_q;
  assign mem_we_o      = mem_we_q;
  assign mem_addr_o    = {blk_q, 6'h00};
  assign fill_buf_o    = fb_q;
  assign cache_copy_o  = cache_copy_q;
  assign cpu_mem_gnt_o = cpu_gnt_q;
  assign qw_req_o      = qw_req_q;
  assign qw_buf_o      = qw_buf_q;
  assign qw_idx_o      = qw_idx_q;
  assign qw_src_o      = qw_src_q;
  assign pw_we_o       = pw_we_q;
  assign pw_idx_o      = pw_idx_q;
  assign pw_data_o     = pw_data_q;
  assign pw_ecc_o      = pw_ecc_q;
  assign io_rd_go_o    = io_go_q;

endmodule

// >>> logic/pdm_dma_defs.vh
`ifndef PDM_DMA_DEFS_VH
`define PDM_DMA_DEFS_VH

// ----------------------------------------
// pci memory commands
// ----------------------------------------
`define PDM_CMD_MR      4'h6
`define PDM_CMD_MRL     4'he
`define PDM_CMD_MRM     4'hc
`define PDM_CMD_MW      4'h7
`define PDM_CMD_MWI     4'hf

// ----------------------------------------
// fetch engine states
// ----------------------------------------
`define PDM_ST_IDLE     4'h0
`define PDM_ST_OWN      4'h1
`define PDM_ST_PROBE    4'h2
`define PDM_ST_MEM      4'h3
`define PDM_ST_RIDLE    4'h4
`define PDM_ST_WDATA    4'h5
`define PDM_ST_WMERGE   4'h6
`define PDM_ST_COMMIT   4'h7
`define PDM_ST_WAITW    4'h8

// ----------------------------------------
// memory owner codes
// ----------------------------------------
`define PDM_OWN_NONE    2'h0
`define PDM_OWN_CPU     2'h1
`define PDM_OWN_DMA     2'h2

// ----------------------------------------
// data switch buffer portions
// ----------------------------------------
`define PDM_SRC_MEM     2'h0
`define PDM_SRC_CACHE   2'h1

// ----------------------------------------
// block, page and check code layout
// ----------------------------------------
`define PDM_PAGE_LAST   7'h7f
`define PDM_QW_LAST     3'h7
`define PDM_QW_COUNT    4'h8
`define PDM_BE_ALL      8'hff
`define PDM_ECC_TAG     2'h3

`endif

// >>> testbench/pdm_dma_path_asserts.sv
`timescale 1ns/10ps
`include "pdm_dma_defs.vh"
module pdm_dma_path_asserts (
  input logic        clock_i,
  input logic        srst_i,
  input logic        dma_req_i,
  input logic [3:0]  dma_cmd_i,
  input logic [31:0] dma_addr_i,
  input logic        dma_end_i,
  input logic        dma_busy_o,
  input logic [63:0] rd_data_o,
  input logic        rd_valid_o,
  input logic        rd_ready_i,
  input logic [7:0]  wr_be_i,
  input logic        wr_valid_i,
  input logic        wr_ready_o,
  input logic        probe_req_o,
  input logic        probe_flush_o,
  input logic        probe_ack_i,
  input logic        probe_dirty_i,
  input logic        mem_req_o,
  input logic        mem_we_o,
  input logic [31:0] mem_addr_o,
  input logic        cache_copy_o,
  input logic        cpu_mem_gnt_o,
  input logic        qw_req_o,
  input logic        pw_we_o,
  input logic        io_rd_req_i,
  input logic        cpu_io_wr_pend_i,
  input logic        io_rd_go_o
);
  // ----------
  // kind and page of the accepted request
  // ----------
  logic        rd_mode_q;
  logic [18:0] page_q;
  wire         is_rd = dma_cmd_i == `PDM_CMD_MR || dma_cmd_i == `PDM_CMD_MRL ||
                       dma_cmd_i == `PDM_CMD_MRM;
  // latch on the edge a request is taken
  always @(posedge clock_i) begin
    if (srst_i) begin
      rd_mode_q <= 1'b0;
      page_q    <= 19'h0_0000;
    end else if (dma_req_i && !dma_busy_o) begin
      rd_mode_q <= is_rd;
      page_q    <= dma_addr_i[31:13];
    end
  end
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (srst_i);
  // ----------
  // properties
  // ----------
  probe_owned_a: assert property (probe_req_o |-> !cpu_mem_gnt_o)
    else $error("probe while cpu owns memory");
  probe_kind_a: assert property (probe_req_o |-> probe_flush_o == !rd_mode_q)
    else $error("wrong probe kind");
  cpu_excl_a: assert property (mem_req_o |-> !cpu_mem_gnt_o ##1 !cpu_mem_gnt_o)
    else $error("cpu granted during dma access");
  ack_fetch_a: assert property (probe_ack_i |=> mem_req_o && !mem_we_o)
    else $error("no memory read after probe");
  hold_data_a: assert property (rd_valid_o && !rd_ready_i && !dma_end_i
    |=> rd_valid_o && $stable(rd_data_o)) else $error("read data not held");
  end_drop_a: assert property (dma_end_i |=> !rd_valid_o)
    else $error("read data after end");
  pw_unused_a: assert property (pw_we_o |-> !rd_mode_q)
    else $error("write portion used by read");
  page_stop_a: assert property (mem_req_o && rd_mode_q |-> mem_addr_o[31:13] == page_q)
    else $error("fetch beyond page");
  full_ecc_a: assert property (wr_valid_i && wr_ready_o && wr_be_i == `PDM_BE_ALL
    |=> pw_we_o) else $error("full quadword not stored");
  part_merge_a: assert property (wr_valid_i && wr_ready_o && wr_be_i != `PDM_BE_ALL
    |=> qw_req_o && !pw_we_o) else $error("partial quadword not merged");
  block_align_a: assert property (mem_req_o |-> mem_addr_o[5:0] == 6'h00)
    else $error("memory address not block aligned");
  io_wait_a: assert property (io_rd_req_i && cpu_io_wr_pend_i |=> !io_rd_go_o)
    else $error("io read ahead of writes");
  io_pass_a: assert property (io_rd_req_i && !cpu_io_wr_pend_i |=> io_rd_go_o)
    else $error("io read held with no pending writes");
  ack_copy_a: assert property (probe_ack_i |=> cache_copy_o == $past(probe_dirty_i))
    else $error("dirty copy not flagged");
  cover property (cache_copy_o);
  cover property (mem_req_o && mem_we_o);
  cover property (rd_valid_o && !rd_ready_i);
  cover property (cpu_mem_gnt_o);
endmodule
bind pdm_dma_path pdm_dma_path_asserts u_pdm_dma_path_asserts (.*);

// >>> testbench/pdm_pci_master.sv
`timescale 1ns/10ps
module pdm_pci_master (
  input  logic        clock_i,
  input  logic        dma_busy_i,
  input  logic [63:0] rd_data_i,
  input  logic        rd_valid_i,
  input  logic        wr_ready_i,
  output logic        dma_req_o,
  output logic [3:0]  dma_cmd_o,
  output logic [31:0] dma_addr_o,
  output logic        dma_end_o,
  output logic        rd_ready_o,
  output logic [63:0] wr_data_o,
  output logic [7:0]  wr_be_o,
  output logic        wr_valid_o
);
  logic [63:0] got [0:63];
  logic [63:0] wd [0:7];
  logic [7:0]  wb [0:7];
  integer      seed = 74961;
  // idle bus
  initial begin
    {dma_req_o, dma_cmd_o, dma_addr_o, dma_end_o} = 38'h0;
    {rd_ready_o, wr_data_o, wr_be_o, wr_valid_o} = 74'h0;
  end
  // one request once the engine is idle
  task automatic start(input logic [3:0] c, input logic [31:0] a);
    begin
      while (dma_busy_i !== 1'b0) @(negedge clock_i);
      dma_cmd_o  = c;
      dma_addr_o = a;
      dma_req_o  = 1'b1;
      @(negedge clock_i);
      dma_req_o = 1'b0;
    end
  endtask
  // accept n quadwords, stalling at random when slow
  task automatic rd(input int n, input int slow);
    int k;
    begin
      k = 0;
      while (k < n) begin
        rd_ready_o = (slow == 0) || (($random(seed) & 3) == 0);
        @(posedge clock_i);
        if (rd_valid_i === 1'b1 && rd_ready_o) begin
          got[k] = rd_data_i;
          k++;
        end
        @(negedge clock_i);
      end
      rd_ready_o = 1'b0;
      dma_end_o  = 1'b1;
      @(negedge clock_i);
      dma_end_o = 1'b0;
    end
  endtask
  // offer n quadwords, each held until accepted
  task automatic wr(input int n);
    begin
      for (int k = 0; k < n; k++) begin
        wr_data_o  = wd[k];
        wr_be_o    = wb[k];
        wr_valid_o = 1'b1;
        @(posedge clock_i);
        while (wr_ready_i !== 1'b1) @(posedge clock_i);
        @(negedge clock_i);
      end
      wr_valid_o = 1'b0;
      wr_data_o  = ~wr_data_o;
      dma_end_o  = 1'b1;
      @(negedge clock_i);
      dma_end_o = 1'b0;
    end
  endtask
endmodule

// >>> testbench/tb_top.sv
`timescale 1ns/10ps
`include "pdm_dma_defs.vh"
module tb_top;
  logic clock_i, srst_i, dma_req_i, dma_end_i, dma_busy_o, rd_valid_o, rd_ready_i;
  logic wr_valid_i, wr_ready_o, probe_req_o, probe_flush_o, probe_ack_i, probe_dirty_i;
  logic mem_req_o, mem_we_o, fill_buf_o, cache_copy_o, mem_done_i, cpu_mem_req_i;
  logic cpu_mem_done_i, cpu_mem_gnt_o, qw_req_o, qw_buf_o, qw_valid_i, pw_we_o;
  logic io_rd_req_i, cpu_io_wr_pend_i, io_rd_go_o;
  logic [3:0]  dma_cmd_i;
  logic [31:0] dma_addr_i, probe_addr_o, mem_addr_o, wa, err_a, qa, pa;
  logic [63:0] rd_data_o, wr_data_i, qw_data_i, pw_data_o, qd;
  logic [7:0]  wr_be_i, qw_ecc_i, pw_ecc_o;
  logic [2:0]  qw_idx_o, pw_idx_o;
  logic [1:0]  qw_src_o;
  logic [31:0] bufa [0:1];
  logic [63:0] pwd [0:7];
  logic [63:0] expw [0:7];
  logic [7:0]  pwe [0:7];
  logic [3:0]  rc [0:2];
  logic        dirty_en;
  integer      seed = 74961;
  integer      mismatches = 0;
  integer      num_checks = 0;
  integer      nrd, nwr;
  pdm_dma_path u_pdm_dma_path (.*);
  pdm_pci_master u_pdm_pci_master (
    .clock_i   (clock_i),
    .dma_busy_i(dma_busy_o),
    .rd_data_i (rd_data_o),
    .rd_valid_i(rd_valid_o),
    .wr_ready_i(wr_ready_o),
    .dma_req_o (dma_req_i),
    .dma_cmd_o (dma_cmd_i),
    .dma_addr_o(dma_addr_i),
    .dma_end_o (dma_end_i),
    .rd_ready_o(rd_ready_i),
    .wr_data_o (wr_data_i),
    .wr_be_o   (wr_be_i),
    .wr_valid_o(wr_valid_i)
  );
  // ----------
  // expectations and comparisons
  // ----------
  function automatic logic [63:0] dat(input logic [31:0] a, input logic c);
    dat = {a, ~a} ^ (c ? 64'h5555_5555_5555_5555 : 64'h0);
  endfunction
  function automatic logic [7:0] ecc(input logic [63:0] d);
    ecc = 8'h00;
    for (int j = 0; j < 64; j++) if (d[j]) ecc = ecc ^ {2'b11, 6'(j)};
  endfunction
  task automatic cmp_d(input logic [63:0] got, input logic [63:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %0t %s %h %h", $time, m, got, exp);
    end
  endtask
  task automatic cmp_n(input int got, input int exp, input string m);
    num_checks++;
    if (got != exp) begin
      mismatches++;
      $display("unexpected %0t %s %0d %0d", $time, m, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wait_idle;
    int k;
    k = 0;
    while (dma_busy_o !== 1'b0 && k < 2000) begin
      @(negedge clock_i);
      k++;
    end
    cmp_n(int'(k < 2000), 1, "engine stuck");
  endtask
  task automatic rd_case(input logic [3:0] c, input logic [31:0] a, input int n, s, er);
    nrd = 0;
    u_pdm_pci_master.start(c, a);
    u_pdm_pci_master.rd(n, s);
    wait_idle();
    for (int k = 0; k < n; k++) cmp_d(u_pdm_pci_master.got[k], dat(a + 32'(8 * k), dirty_en), "rd");
    if (er > 0) cmp_n(nrd, er, "block fetches");
    $display("read case %h done", a);
  endtask
  task automatic wr_case(input logic [3:0] c, input logic [31:0] a, input int n);
    logic [63:0] d;
    logic [7:0]  m;
    int          s;
    s   = int'(a[5:3]);
    nwr = 0;
    wa  = {a[31:6], 6'h00};
    for (int i = 0; i < 8; i++) expw[i] = dat(wa | 32'(8 * i), dirty_en);
    for (int k = 0; k < n; k++) begin
      d = {$random(seed), $random(seed)};
      m = ($random(seed) & 1) ? 8'hff : 8'($random(seed));
      u_pdm_pci_master.wd[k] = d;
      u_pdm_pci_master.wb[k] = m;
      for (int b = 0; b < 8; b++) if (m[b]) expw[s + k][8 * b +: 8] = d[8 * b +: 8];
    end
    u_pdm_pci_master.start(c, a);
    u_pdm_pci_master.wr(n);
    wait_idle();
    cmp_n(nwr, 1, "block commits");
    $display("write case %h done", a);
  endtask
  // ----------
  // far side responders
  // ----------
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  // capture stores into the write portion
  always @(posedge clock_i) if (pw_we_o === 1'b1) begin
    pwd[pw_idx_o] <= pw_data_o;
    pwe[pw_idx_o] <= pw_ecc_o;
  end
  // cache probe answers
  initial forever begin
    @(posedge clock_i);
    if (probe_req_o === 1'b1) begin
      pa = probe_addr_o;
      repeat (1 + ($random(seed) & 3)) @(negedge clock_i);
      probe_ack_i   = 1'b1;
      probe_dirty_i = dirty_en;
      @(negedge clock_i);
      probe_ack_i   = 1'b0;
      probe_dirty_i = 1'b0;
    end
  end
  // memory array, checks each committed block
  initial forever begin
    @(posedge clock_i);
    if (mem_req_o === 1'b1) begin
      if (mem_we_o === 1'b0) begin
        bufa[fill_buf_o] = mem_addr_o;
        nrd++;
        cmp_d({32'h0, mem_addr_o}, {32'h0, pa}, "probe address");
      end else begin
        nwr++;
        cmp_d({32'h0, mem_addr_o}, {32'h0, wa}, "write address");
        cmp_d({32'h0, pa}, {32'h0, wa}, "flush address");
        for (int i = 0; i < 8; i++) begin
          cmp_d(pwd[i], expw[i], "merged data");
          cmp_d({56'h0, pwe[i]}, {56'h0, ecc(expw[i])}, "check code");
        end
      end
      repeat (2 + ($random(seed) & 3)) @(negedge clock_i);
      mem_done_i = 1'b1;
      @(negedge clock_i);
      mem_done_i = 1'b0;
    end
  end
  // data switch quadword answers, one bit spoiled at err_a
  initial forever begin
    @(posedge clock_i);
    if (qw_req_o === 1'b1) begin
      qa = bufa[qw_buf_o] | {26'h0, qw_idx_o, 3'h0};
      qd = dat(qa, qw_src_o == `PDM_SRC_CACHE);
      repeat (1 + ($random(seed) & 1)) @(negedge clock_i);
      qw_ecc_i   = ecc(qd);
      qw_data_i  = qd ^ ((qa === err_a) ? 64'h0000_0000_0001_0000 : 64'h0);
      qw_valid_i = 1'b1;
      @(negedge clock_i);
      qw_valid_i = 1'b0;
      qw_data_i  = ~qw_data_i;
    end
  end
  // cpu memory sequences and io traffic
  initial begin
    wait (srst_i === 1'b0);
    forever begin
      @(negedge clock_i);
      {io_rd_req_i, cpu_io_wr_pend_i} = 2'($random(seed));
      if (($random(seed) & 31) == 0) begin
        cpu_mem_req_i = 1'b1;
        repeat (3) @(negedge clock_i);
        while (cpu_mem_gnt_o !== 1'b1) @(negedge clock_i);
        cpu_mem_req_i  = 1'b0;
        cpu_mem_done_i = 1'b1;
        @(negedge clock_i);
        cpu_mem_done_i = 1'b0;
      end
    end
  end
  // watchdog
  initial begin
    #2_000_000;
    mismatches++;
    $display("unexpected %0t watchdog", $time);
    end_sim();
  end
  // ----------
  // main sequence
  // ----------
  initial begin
    {probe_ack_i, probe_dirty_i, mem_done_i, cpu_mem_req_i} = 4'h0;
    {cpu_mem_done_i, qw_valid_i, io_rd_req_i, cpu_io_wr_pend_i} = 4'h0;
    {qw_data_i, qw_ecc_i} = 72'h0;
    {rc[0], rc[1], rc[2]} = {`PDM_CMD_MR, `PDM_CMD_MRL, `PDM_CMD_MRM};
    srst_i   = 1'b1;
    dirty_en = 1'b0;
    err_a    = 32'hffff_ffff;
    repeat (8) @(posedge clock_i);
    @(negedge clock_i);
    srst_i = 1'b0;
    rd_case(`PDM_CMD_MR, 32'h0000_1018, 3, 0, 1);
    rd_case(`PDM_CMD_MRL, 32'h0000_2000, 2, 1, 2);
    rd_case(`PDM_CMD_MR, 32'h0000_2040, 2, 0, 1);
    rd_case(`PDM_CMD_MRM, 32'h0000_5fc0, 4, 1, 1);
    dirty_en = 1'b1;
    err_a    = 32'h0000_3020;
    rd_case(`PDM_CMD_MRM, 32'h0000_3008, 30, 1, 0);
    err_a = 32'hffff_ffff;
    wr_case(`PDM_CMD_MW, 32'h0000_0818, 3);
    dirty_en = 1'b0;
    wr_case(`PDM_CMD_MWI, 32'h0000_0c00, 8);
    for (int i = 0; i < 6; i++) begin
      wa = $random(seed) & 32'hffff_eff8;
      rd_case(rc[i % 3], wa, 1 + (i * 5) % 12, i % 2, 0);
      wa = $random(seed) & 32'hffff_fff8;
      wr_case(`PDM_CMD_MW, wa, 8 - int'(wa[5:3]));
    end
    end_sim();
  end
endmodule
